/* core/tmc_timer0.sv */
`timescale 1ns/1ps
// Function
// - source select zero: count instruction cycles
// - low byte write stalls two cycles
// - source one: count pin edges, edge selectable
// - pin synchronised before counting
// - hidden 8-bit prescaler counter
// - prescaler ratios 1:2 to 1:256
// - low byte write clears prescaler while it is assigned
// - prescaler assignment changeable any time
// - rollover sets overflow flag
// - interrupt request gated by enable bit
// - flag sets regardless of enables
// - counter stops during sleep
// - high byte only via buffer
// - low read captures high byte
// - low write loads high byte
// - control register layout, resets all ones
// - low byte kept across resets
module tmc_timer0 import tmc_pkg::*; #(
  parameter int INSTR_DIV = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // core state
  input wire logic sleepMode,
  input wire logic externalCountPin,
  output logic overflowIrq,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // refuse dividers the 8-bit tick counter cannot reach
  if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_div
    $error("INSTR_DIV out of range");
  end
  // field positions must sit inside the byte-wide registers
  if (CTRL_RUN > 7 || CTRL_RATIO_MSB > 7 || INT_ENABLE > 7 || INT_FLAG > 7) begin : g_bad_field
    $error("register field outside a byte");
  end
  // the write stall needs a nonzero count
  if (WRITE_HOLD_CYCLES == 2'h0) begin : g_bad_hold
    $error("write stall count is zero");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus write channel
  logic awHeld_q;
  logic wHeld_q;
  logic [3:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic doWrite;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;

  // write address holding register, either order with data
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end
  end

  // write data holding register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
    end
  end

  logic addrOk;
  assign addrOk = (awAddr_q == OFS_COUNT_LOW) || (awAddr_q == OFS_HIGH_BUF) ||
                  (awAddr_q == OFS_INT_CTRL) || (awAddr_q == OFS_CTRL);

  // write response one cycle after both halves are held
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q <= addrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  logic wrLow;
  logic wrHigh;
  logic wrInt;
  logic wrCtrl;
  // register write strobes, low byte lane only
  always_comb begin
    wrLow = 1'b0;
    wrHigh = 1'b0;
    wrInt = 1'b0;
    wrCtrl = 1'b0;
    if (doWrite && wStrb_q[0]) begin
      unique case (awAddr_q)
        OFS_COUNT_LOW: wrLow = 1'b1;
        OFS_HIGH_BUF: wrHigh = 1'b1;
        OFS_INT_CTRL: wrInt = 1'b1;
        OFS_CTRL: wrCtrl = 1'b1;
        default: wrLow = 1'b0; // unmapped: no effect
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and buffer registers
  logic [7:0] ctrl_q;
  logic [7:0] highBuf_q;
  logic [7:0] intCtrl_q;
  logic [7:0] countLow_q;
  logic [7:0] countHigh_q;
  logic overflowEvt;
  logic rdLow;

  // control register, all ones at reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= wData_q[7:0];
    end
  end

  // high buffer: software writes, low-byte read captures
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      highBuf_q <= HIGH_BUF_RESET;
    end else if (rdLow) begin
      highBuf_q <= countHigh_q;
    end else if (wrHigh) begin
      highBuf_q <= wData_q[7:0];
    end
  end

  // interrupt control, flag set wins over clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      intCtrl_q <= INT_CTRL_RESET;
    end else begin
      if (wrInt) begin
        intCtrl_q <= wData_q[7:0];
      end
      if (overflowEvt) begin
        intCtrl_q[INT_FLAG] <= 1'b1;
      end
    end
  end

  // request gated by enable only
  assign overflowIrq = intCtrl_q[INT_FLAG] && intCtrl_q[INT_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle enable and pin synchroniser
  logic [7:0] divCnt_q;
  logic instrTick;
  assign instrTick = divCnt_q == 8'(INSTR_DIV - 1);

  // divide system clock to instruction rate
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= 8'h00;
    end else if (instrTick) begin
      divCnt_q <= 8'h00;
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
    end
  end

  logic pinMeta_q;
  logic pinSync_q;
  logic pinPrev_q;
  // two-stage synchroniser then edge history
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      pinPrev_q <= 1'b0;
    end else begin
      pinMeta_q <= externalCountPin;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  logic pinRise;
  logic pinFall;
  // single-clock pulses on each synchronised transition
  assign pinRise = !pinPrev_q && pinSync_q;
  assign pinFall = pinPrev_q && !pinSync_q;

  logic pinEdge;
  // rising when edge bit zero, falling when one
  assign pinEdge = ctrl_q[CTRL_EDGE] ? pinFall : pinRise;

  logic tickEvt_q;
  // instruction tick delayed to line up with the registered source event
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tickEvt_q <= 1'b0;
    end else begin
      tickEvt_q <= instrTick;
    end
  end

  logic srcEvt_q;
  // registered source event gives the post-sync delay
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      srcEvt_q <= 1'b0;
    end else begin
      srcEvt_q <= ctrl_q[CTRL_SRC] ? pinEdge : instrTick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler
  logic [7:0] presc_q;
  logic [7:0] prescMask;
  logic prescOut;
  assign prescMask = 8'((9'h002 << ctrl_q[CTRL_RATIO_MSB:CTRL_RATIO_LSB]) - 9'h001);
  assign prescOut = ((presc_q & prescMask) == prescMask);

  logic runEn;
  assign runEn = ctrl_q[CTRL_RUN] && !sleepMode;

  logic prescAssigned;
  logic prescClear;
  logic prescAdvance;
  // prescaler belongs to this counter while the bypass bit is low
  assign prescAssigned = !ctrl_q[CTRL_BYPASS];
  assign prescClear = wrLow && prescAssigned;
  assign prescAdvance = srcEvt_q && runEn && prescAssigned;

  // hidden counter, cleared by a low-byte write while the bypass bit is low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      presc_q <= 8'h00;
    end else if (prescClear) begin
      presc_q <= 8'h00;
    end else if (prescAdvance) begin
      presc_q <= presc_q + 8'h01;
    end
  end

  logic countEvt;
  // bypass counts each event, else prescaler terminal
  assign countEvt = srcEvt_q && runEn && (ctrl_q[CTRL_BYPASS] || prescOut);

  ////////////////////////////////////////////////////////////////////////////
  // counter proper
  logic [1:0] hold_q;
  // inhibit window after low-byte write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 2'h0;
    end else if (wrLow) begin
      hold_q <= WRITE_HOLD_CYCLES;
    end else if (tickEvt_q && hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end

  logic lowWrap;
  logic highWrap;
  // byte rollover conditions
  assign lowWrap = countLow_q == 8'hFF;
  assign highWrap = countHigh_q == 8'hFF;

  logic doInc;
  assign doInc = countEvt && hold_q == 2'h0 && !wrLow;
  assign overflowEvt = doInc && lowWrap && (ctrl_q[CTRL_EIGHT] || highWrap);

  // count bytes have no reset: kept through soft resets
  always_ff @(posedge clock) begin
    if (wrLow) begin
      countLow_q <= wData_q[7:0];
      countHigh_q <= highBuf_q;
    end else if (doInc) begin
      countLow_q <= countLow_q + 8'h01;
      if (!ctrl_q[CTRL_EIGHT] && lowWrap) begin
        countHigh_q <= countHigh_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read channel
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  assign s_axi_arready = !rValid_q;
  assign rdLow = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_COUNT_LOW;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  logic [7:0] rdByte;
  logic rdHit;
  // decode read address into a byte and a hit flag
  always_comb begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      OFS_COUNT_LOW: rdByte = countLow_q;
      OFS_HIGH_BUF: rdByte = highBuf_q;
      OFS_INT_CTRL: rdByte = intCtrl_q;
      OFS_CTRL: rdByte = ctrl_q;
      default: rdHit = 1'b0;
    endcase
  end

  // read data one cycle after address
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_q <= 1'b1;
      rData_q <= {24'h00_0000, rdByte};
      rResp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

endmodule : tmc_timer0

/* core/tmc_pkg.sv */
package tmc_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] OFS_COUNT_LOW = 4'h0;
  localparam logic [3:0] OFS_HIGH_BUF = 4'h4;
  localparam logic [3:0] OFS_INT_CTRL = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hC;
  // counter control field positions
  localparam int CTRL_RUN = 7;
  localparam int CTRL_EIGHT = 6;
  localparam int CTRL_SRC = 5;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_BYPASS = 3;
  localparam int CTRL_RATIO_MSB = 2;
  localparam int CTRL_RATIO_LSB = 0;
  // interrupt control field positions
  localparam int INT_ENABLE = 5;
  localparam int INT_FLAG = 2;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'hFF;
  localparam logic [7:0] HIGH_BUF_RESET = 8'h00;
  localparam logic [7:0] INT_CTRL_RESET = 8'h00;
  // instructions after a low byte write with no increment
  localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tmc_pkg

/* tb/tmc_pin_model.sv */
`timescale 1ns/1ps
module tmc_pin_model (
  // clock
  input wire logic clock,
  // count pin
  output logic pinLevel
);
  initial pinLevel = 1'b0;
  // toggle the pin n times, four clocks per level
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock);
      pinLevel <= ~pinLevel;
    end
    repeat (8) @(posedge clock);
  endtask : toggle
endmodule : tmc_pin_model

/* tb/tmc_timer0_assertions.sv */
`timescale 1ns/1ps
module tmc_timer0_chk import tmc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // core
  input wire logic sleepMode,
  input wire logic overflowIrq,
  // write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read side
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_unmapped_read: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr[1:0] != 2'b00
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
  a_mapped_read: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr[1:0] == 2'b00
    |=> s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
  a_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while answering");
  a_sleep_quiet: assert property (sleepMode && $past(sleepMode, 3) && !s_axi_bvalid |-> !$rose(overflowIrq))
    else $error("overflow during sleep");
endmodule : tmc_timer0_chk
bind tmc_timer0 tmc_timer0_chk u_tmc_timer0_chk (.*);

/* tb/tb_tmc_timer0.sv */
`timescale 1ns/1ps
module tb_tmc_timer0 import tmc_pkg::*; ;
  logic clock = 0, rst_b = 0, sleepMode = 0, pin, irq, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hF;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, r, wb;
  logic [7:0] v1, v2;
  int failures = 0, cmp_count = 0, cyc = 0, rdCyc;
  // clock and cycle ceiling
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      failures++;
      report_and_stop();
    end
  end
  tmc_timer0 #(.INSTR_DIV(1)) u_tmc_timer0 (.clock(clock), .rst_b(rst_b), .sleepMode(sleepMode),
    .externalCountPin(pin), .overflowIrq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tmc_pin_model u_tmc_pin_model (.clock(clock), .pinLevel(pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  // bus write, channels released as taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    wb = bresp;
    bready <= 0;
    @(posedge clock);
  endtask : wr
  // bus read, accept cycle noted
  task automatic rd(input logic [3:0] a, output logic [7:0] v, output logic [1:0] rr);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clock); while (!arready);
    rdCyc = cyc;
    arvalid <= 0;
    do @(posedge clock); while (!rvalid);
    v = rdata[7:0];
    rr = rresp;
    rready <= 0;
    @(posedge clock);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(OFS_CTRL, v1, r); check(v1, 8'hFF, "ctrl reset");
    rd(OFS_HIGH_BUF, v1, r); check(v1, 8'h00, "buffer reset");
    rd(4'h2, v1, r); check(r, RESP_SLVERR, "unmapped");
    wr(4'h2, 8'h00); check(wb, RESP_SLVERR, "unmapped write");
    wr(OFS_HIGH_BUF, 8'h00); check(wb, RESP_OKAY, "mapped write");
  endtask : t_regs
  // high byte only through the buffer
  task automatic t_buffer();
    wr(OFS_CTRL, 8'h08); wr(OFS_HIGH_BUF, 8'h12); wr(OFS_COUNT_LOW, 8'h34); wr(OFS_HIGH_BUF, 8'h00);
    rd(OFS_COUNT_LOW, v1, r); check(v1, 8'h34, "low");
    rd(OFS_HIGH_BUF, v1, r); check(v1, 8'h12, "captured high");
  endtask : t_buffer
  // every ratio, changed while running
  task automatic t_rate();
    int p, t0;
    for (int c = 0; c < 9; c++) begin
      p = (c == 8) ? 1 : (2 << c);
      wr(OFS_CTRL, (c == 8) ? 8'h88 : 8'h80 | c[7:0]);
      wr(OFS_COUNT_LOW, 8'h00);
      rd(OFS_COUNT_LOW, v1, r); check(v1 >> 1, 0, "write stall");
      t0 = rdCyc;
      do @(posedge clock); while ((cyc + 1 - t0) % p != 0 || cyc + 1 - t0 < 8 * p);
      rd(OFS_COUNT_LOW, v2, r); check(8'(v2 - v1), 8'((rdCyc - t0) / p), "rate");
    end
  endtask : t_rate
  // rising then falling pin edges
  task automatic t_pin();
    for (int e = 0; e < 2; e++) begin
      wr(OFS_CTRL, e ? 8'hB8 : 8'hA8);
      rd(OFS_COUNT_LOW, v1, r); u_tmc_pin_model.toggle(3);
      rd(OFS_COUNT_LOW, v2, r); check(8'(v2 - v1), 2, "pin edges");
    end
  endtask : t_pin
  // frozen in sleep and with run off
  task automatic t_freeze();
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CTRL, s ? 8'h08 : 8'h88);
      sleepMode <= !s;
      rd(OFS_COUNT_LOW, v1, r); repeat (20) @(posedge clock);
      rd(OFS_COUNT_LOW, v2, r); check(v2, v1, "frozen");
      sleepMode <= 0;
    end
  endtask : t_freeze
  // overflow per mode, flag polled, request gated
  task automatic t_overflow();
    logic [7:0] ct[3] = '{8'hC8, 8'h88, 8'h88};
    logic [7:0] hb[3] = '{8'h00, 8'hFF, 8'h00};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 8'h08); wr(OFS_INT_CTRL, 8'h00); wr(OFS_HIGH_BUF, hb[i]);
      wr(OFS_CTRL, ct[i]); wr(OFS_COUNT_LOW, 8'hF0);
      repeat (40) @(posedge clock);
      wr(OFS_CTRL, 8'h08); check(irq, 0, "masked");
      rd(OFS_INT_CTRL, v1, r); check(v1, (i < 2) ? 8'h04 : 8'h00, "flag");
      wr(OFS_INT_CTRL, v1 | 8'h20); check(irq, i < 2, "irq");
    end
  endtask : t_overflow
  // low byte kept over reset
  task automatic t_reset();
    wr(OFS_CTRL, 8'h08); wr(OFS_COUNT_LOW, 8'h5A);
    rst_b <= 0; repeat (3) @(posedge clock); rst_b <= 1; @(posedge clock);
    rd(OFS_COUNT_LOW, v1, r); check(v1, 8'h5A, "kept");
    rd(OFS_CTRL, v1, r); check(v1, 8'hFF, "ctrl");
  endtask : t_reset
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    t_regs(); t_buffer(); t_rate(); t_pin(); t_freeze(); t_overflow(); t_reset();
    report_and_stop();
  end
endmodule : tb_tmc_timer0
